// *** include/ldp_cfg.svh ***
`ifndef LDP_CFG_SVH
`define LDP_CFG_SVH
// ----------------------------------------------------------------
// Clock and switching rate
// ----------------------------------------------------------------
`define LDP_CLK_HZ      40000000
`define LDP_FSW_HZ      72000
`define LDP_FSW_CYC     (`LDP_CLK_HZ / `LDP_FSW_HZ)
`define LDP_SOFT_MS     10
`define LDP_SUB_MS      500
// ----------------------------------------------------------------
// Fault counts
// ----------------------------------------------------------------
`define LDP_OCP_RUN     4
`define LDP_SHORT_RUN   4
// ----------------------------------------------------------------
// Thermal thresholds, degrees C and millivolts
// ----------------------------------------------------------------
`define LDP_T_START     8'd130
`define LDP_T_SHUT      8'd150
`define LDP_T_STEP      8'd10
`define LDP_T_HYST      8'd10
`define LDP_T_BASE0     8'd100
`define LDP_T_BASE1     8'd90
`define LDP_T_BASE2     8'd110
`define LDP_V_SHUT      11'd540
`define LDP_V_START     11'd840
`define LDP_V_BASE      11'd1400
`define LDP_V_HYST      11'd60
`define LDP_V_STEP0     11'd100
`define LDP_V_STEP1     11'd150
`define LDP_V_STEP2     11'd200
// ----------------------------------------------------------------
// Current scale, per mille of nominal
// ----------------------------------------------------------------
`define LDP_NOM_PM      10'd1000
`define LDP_LVL_PM      10'd70
`define LDP_SUB_PM      10'd14
// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define LDP_A_CTRL      4'h0
`define LDP_A_STAT      4'h4
`define LDP_A_SCALE     4'h8
`define LDP_F_TSEL      1:0
`define LDP_F_VSEL      3:2
`define LDP_CTRL_RST    4'h0
`define LDP_RESP_OK     2'b00
`define LDP_RESP_ERR    2'b10
`endif

// *** include/ldp_pkg.sv ***
package ldp_pkg;
  typedef enum logic [2:0] {
    LDP_S_UVLO  = 3'b000,
    LDP_S_CHECK = 3'b001,
    LDP_S_SOFT  = 3'b010,
    LDP_S_RUN   = 3'b011,
    LDP_S_FAULT = 3'b100
  } ldp_state_t;

  typedef enum logic [2:0] {
    LDP_C_NONE  = 3'b000,
    LDP_C_OCP   = 3'b001,
    LDP_C_SRS   = 3'b010,
    LDP_C_SHORT = 3'b011,
    LDP_C_HOT   = 3'b100
  } ldp_cause_t;
endpackage : ldp_pkg

// *** rtl/ldp_fault_derate.sv ***
// Functional notes
// - Over-current above 1.15V ends the present gate pulse for that cycle.
// - A new gate pulse is issued next cycle and cut only on retrip.
// - Consecutive tripped switching cycles are counted; a run shuts down.
// - A shorted sense resistor seen during start-up shuts down at once.
// - After a fault, wait for undervoltage lockout, reset, retry soft-start.
// - Start-up repeats and never reaches switching while the short persists.
// - Junction above 130C before soft-start inhibits start-up.
// - When running, 150C junction is the thermal shutdown threshold.
// - Internal mode steps derating level up at each 10C threshold.
// - Each derating level lowers current command by about 7 percent.
// - Each level is applied as several small decrements over seconds.
// - Each threshold has 10C hysteresis before the level is left.
// - Hold between threshold-10 and next threshold; below, ramp back up.
// - Derating start temperature is chosen among three configured levels.
// - External mode steps on thermistor voltage thresholds with hysteresis.
// - External step size is fixed by a setting captured in the start-up check state.
// - External mode shuts down when thermistor voltage is below 0.54V.
// - External mode starts only with thermistor voltage above 0.84V.
// - Derating source is a fixed variant option; switching at 72kHz.
// - Output sample below 115mV for several cycles is a short fault.
`timescale 1ns/1ps
`include "ldp_cfg.svh"

module ldp_fault_derate #(
  parameter bit          EXT_NTC  = 1'b0,
  parameter int          NSTEPS   = 4,
  parameter int unsigned SOFT_CYC = `LDP_CLK_HZ / 1000 * `LDP_SOFT_MS,
  parameter int unsigned SUB_CYC  = `LDP_CLK_HZ / 1000 * `LDP_SUB_MS
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output      logic [1:0]          s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  input  wire logic [31:0]         s_axi_araddr,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  input  wire logic                gate_req,
  input  wire logic                overcurrent_trip,
  input  wire logic                sense_short_guard,
  input  wire logic                uvlo_active,
  input  wire logic                output_short,
  input  wire logic [7:0]          temp_c,
  input  wire logic [10:0]         ntc_mv,
  output      logic                gate_drive,
  output      logic                shutdown,
  output      logic [9:0]          current_scale,
  output      ldp_pkg::ldp_state_t ctrl_state
);
  import ldp_pkg::*;

  initial begin
    if (NSTEPS < 1 || NSTEPS > 7 || SOFT_CYC < 1 || SUB_CYC < 1)
      $error("ldp_fault_derate: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Analog comparators are asynchronous to aclk, so each passes two flops.
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {output_short, uvlo_active, sense_short_guard, overcurrent_trip};
      sync2 <= sync1;
    end
  end
  wire ocp_s   = sync2[0];
  wire srs_s   = sync2[1];
  wire uvlo_s  = sync2[2];
  wire short_s = sync2[3];

  // ----------------------------------------------------------------
  // Switching-cycle divider
  // ----------------------------------------------------------------
  localparam int unsigned FSW_CYC = `LDP_FSW_CYC;
  logic [9:0] sw_cnt;
  wire cyc_start = (sw_cnt == 10'(FSW_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) sw_cnt <= 10'h0;
    else          sw_cnt <= cyc_start ? 10'h0 : sw_cnt + 10'h1;
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic [3:0] ctrl;
  logic [1:0] tsel;
  logic [1:0] vsel;
  logic [2:0] level;
  ldp_state_t state;
  ldp_cause_t cause;

  function automatic logic [7:0] t_base(input logic [1:0] sel);
    unique case (sel)
      2'b01:   t_base = `LDP_T_BASE1;
      2'b10:   t_base = `LDP_T_BASE2;
      default: t_base = `LDP_T_BASE0;
    endcase
  endfunction : t_base

  function automatic logic [10:0] v_step(input logic [1:0] sel);
    unique case (sel)
      2'b01:   v_step = `LDP_V_STEP1;
      2'b10:   v_step = `LDP_V_STEP2;
      default: v_step = `LDP_V_STEP0;
    endcase
  endfunction : v_step

  // ----------------------------------------------------------------
  // Thermal thresholds
  // ----------------------------------------------------------------
  // stepped thresholds
  wire [7:0]  t_up  = t_base(tsel) + 8'(level) * `LDP_T_STEP;
  wire [7:0]  t_dn  = t_up - `LDP_T_STEP - `LDP_T_HYST;
  wire [10:0] v_up  = `LDP_V_BASE - 11'(level) * v_step(vsel);
  wire [10:0] v_dn  = v_up + v_step(vsel) + `LDP_V_HYST;
  wire lvl_max      = (level == 3'(NSTEPS));
  wire hot_up       = EXT_NTC ? (ntc_mv <= v_up) : (temp_c >= t_up);
  wire cool_dn      = EXT_NTC ? (ntc_mv > v_dn) : (temp_c < t_dn);
  wire start_ok     = EXT_NTC ? (ntc_mv > `LDP_V_START) : (temp_c <= `LDP_T_START);
  wire run_hot      = EXT_NTC ? (ntc_mv < `LDP_V_SHUT) : (temp_c >= `LDP_T_SHUT);

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------
  logic [31:0] soft_cnt;
  logic [2:0]  ocp_run;
  logic [2:0]  short_run;
  logic        ocp_cut;
  logic        ocp_seen;
  wire running   = (state == LDP_S_SOFT) || (state == LDP_S_RUN);
  wire ocp_fault = cyc_start && ocp_seen && (ocp_run == 3'(`LDP_OCP_RUN - 1));
  wire shr_fault = cyc_start && short_s && (short_run == 3'(`LDP_SHORT_RUN - 1));
  ldp_state_t next_state;
  ldp_cause_t next_cause;

  always_comb begin
    next_state = state;
    next_cause = cause;
    unique case (state)
      LDP_S_UVLO:  if (!uvlo_s) next_state = LDP_S_CHECK;
      LDP_S_CHECK: if (start_ok) next_state = LDP_S_SOFT;
      LDP_S_SOFT: begin
        if (srs_s) begin
          next_state = LDP_S_FAULT;
          next_cause = LDP_C_SRS;
        end else if (soft_cnt >= SOFT_CYC - 1) begin
          next_state = LDP_S_RUN;
        end
      end
      LDP_S_RUN: begin
        if (ocp_fault) begin
          next_state = LDP_S_FAULT;
          next_cause = LDP_C_OCP;
        end else if (shr_fault) begin
          next_state = LDP_S_FAULT;
          next_cause = LDP_C_SHORT;
        end else if (run_hot) begin
          next_state = LDP_S_FAULT;
          next_cause = LDP_C_HOT;
        end
      end
      LDP_S_FAULT: ;
      default:     next_state = LDP_S_UVLO;
    endcase
    if (uvlo_s) next_state = LDP_S_UVLO;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= LDP_S_UVLO;
      cause <= LDP_C_NONE;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != LDP_S_SOFT) soft_cnt <= 32'h0;
    else                                 soft_cnt <= soft_cnt + 32'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel <= 2'b00;
      vsel <= 2'b00;
    end else if (state == LDP_S_CHECK) begin
      tsel <= ctrl[`LDP_F_TSEL];
      vsel <= ctrl[`LDP_F_VSEL];
    end
  end

  // ----------------------------------------------------------------
  // Cycle-by-cycle over-current
  // ----------------------------------------------------------------
  // cut this pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ocp_cut  <= 1'b0;
      ocp_seen <= 1'b0;
    end else if (ocp_s && running) begin
      ocp_cut  <= 1'b1;
      ocp_seen <= 1'b1;
    end else if (cyc_start) begin
      ocp_cut  <= 1'b0;
      ocp_seen <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != LDP_S_RUN) begin
      ocp_run   <= 3'h0;
      short_run <= 3'h0;
    end else if (cyc_start) begin
      ocp_run   <= ocp_seen ? ocp_run + 3'h1 : 3'h0;
      short_run <= short_s ? short_run + 3'h1 : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Derating level and current ramp
  // ----------------------------------------------------------------
  logic [31:0] sub_cnt;
  wire sub_tick = (sub_cnt >= SUB_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || state != LDP_S_RUN)    level <= 3'h0;
    else if (hot_up && !lvl_max)           level <= level + 3'h1;
    else if (cool_dn && level != 3'h0)     level <= level - 3'h1;
  end

  wire [9:0] target = `LDP_NOM_PM - 10'(level) * `LDP_LVL_PM;
  wire [9:0] dn_val = (current_scale > target + `LDP_SUB_PM) ? current_scale - `LDP_SUB_PM : target;
  wire [9:0] up_val = (current_scale + `LDP_SUB_PM < target) ? current_scale + `LDP_SUB_PM : target;

  always_ff @(posedge aclk) begin
    if (!aresetn || sub_tick) sub_cnt <= 32'h0;
    else                      sub_cnt <= sub_cnt + 32'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != LDP_S_RUN) current_scale <= `LDP_NOM_PM;
    else if (sub_tick && current_scale > target) current_scale <= dn_val;
    else if (sub_tick && current_scale < target) current_scale <= up_val;
  end

  // ----------------------------------------------------------------
  // Driver outputs
  // ----------------------------------------------------------------
  // driver off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_drive <= 1'b0;
      shutdown   <= 1'b1;
      ctrl_state <= LDP_S_UVLO;
    end else begin
      gate_drive <= running && (next_state == state) && gate_req && !ocp_cut && !ocp_s;
      shutdown   <= !running;
      ctrl_state <= state;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are held separately, so either may arrive first.
  logic        aw_got;
  logic        w_got;
  logic        aw_bad;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire wr_go = (aw_got || aw_hs) && (w_got || w_hs) && !s_axi_bvalid;
  wire [3:0]  wr_a = aw_hs ? s_axi_awaddr[3:0] : aw_addr;
  wire [31:0] wr_d = w_hs ? s_axi_wdata : w_data;
  wire [3:0]  wr_s = w_hs ? s_axi_wstrb : w_strb;
  wire wr_hit = (wr_a == `LDP_A_CTRL);
  // A held address keeps its out-of-range mark, so a late data beat cannot land on it.
  wire wr_map = wr_hit && (aw_hs ? (s_axi_awaddr[31:4] == 28'h0) : !aw_bad);
  wire [3:0]  ra   = s_axi_araddr[3:0];
  wire rd_hi  = (s_axi_araddr[31:4] != 28'h0);
  wire rd_map = !rd_hi && (ra == `LDP_A_CTRL || ra == `LDP_A_STAT || ra == `LDP_A_SCALE);
  wire [31:0] stat_word = {21'h0, cause, 2'h0, level, state};
  wire [31:0] rd_word = (ra == `LDP_A_CTRL) ? {28'h0, ctrl} :
                        (ra == `LDP_A_STAT) ? stat_word :
                        (ra == `LDP_A_SCALE) ? {22'h0, current_scale} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_bad  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else if (wr_go) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
    end else begin
      if (aw_hs) aw_got  <= 1'b1;
      if (aw_hs) aw_addr <= s_axi_awaddr[3:0];
      if (aw_hs) aw_bad  <= (s_axi_awaddr[31:4] != 28'h0);
      if (w_hs)  w_got   <= 1'b1;
      if (w_hs)  w_data  <= s_axi_wdata;
      if (w_hs)  w_strb  <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LDP_RESP_OK;
      ctrl          <= `LDP_CTRL_RST;
    end else begin
      if (aw_hs) s_axi_awready <= 1'b0;
      if (w_hs)  s_axi_wready  <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `LDP_RESP_OK : `LDP_RESP_ERR;
        if (wr_map && wr_s[0]) ctrl <= wr_d[3:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `LDP_RESP_OK;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_map ? rd_word : 32'h0;
      s_axi_rresp   <= rd_map ? `LDP_RESP_OK : `LDP_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : ldp_fault_derate

// *** tb/ldp_fault_derate_bench.sv ***
`timescale 1ns/1ps
module ldp_fault_derate_bench;
  import ldp_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, seed, v;
  logic [1:0]  bresp, rresp, trip_mode;
  logic        trip, short_g, uvlo, out_short, gate, shut, bready, rready, greq;
  logic [3:0]  strb;
  logic [7:0]  temp;
  logic [9:0]  scale;
  ldp_state_t  st;
  int          n_fail = 0, num_checks = 0, cyc = 0, t;
  ldp_fault_derate #(.EXT_NTC(1'b0), .NSTEPS(4), .SOFT_CYC(20), .SUB_CYC(10)) i_ldp_fault_derate (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .gate_req(greq), .overcurrent_trip(trip),
    .sense_short_guard(short_g), .uvlo_active(uvlo), .output_short(out_short), .temp_c(temp),
    .ntc_mv(11'd1000), .gate_drive(gate), .shutdown(shut), .current_scale(scale), .ctrl_state(st));
  ldp_plant_model i_ldp_plant_model (.aclk(aclk), .gate_drive(gate), .trip_mode(trip_mode),
    .overcurrent_trip(trip));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always #12.5 aclk = ~aclk;
  // The ceiling sits well above the slowest path through the sequence.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] exp_sc(input int b, input int tc);
    int l;
    l = tc < b ? 0 : (tc - b) / 10 + 1;
    if (l > 4) l = 4;
    return 32'(1000 - 70 * l);
  endfunction : exp_sc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits on state (0), scale (1) or gate (2) with a bounded count.
  task automatic wt(input int sel, input logic [31:0] x, input int lim);
    int i;
    i = 0;
    while ((sel == 0 ? 32'(st) : sel == 1 ? 32'(scale) : 32'(gate)) !== x && i < lim) begin
      @(posedge aclk);
      i++;
    end
    chk(sel == 0 ? 32'(st) : sel == 1 ? 32'(scale) : 32'(gate), x);
  endtask : wt
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, er);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic restart(input ldp_state_t s);
    uvlo <= 1'b1;
    repeat (6) @(posedge aclk);
    uvlo <= 1'b0;
    wt(0, s, 3000);
  endtask : restart
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, short_g, out_short, bready, rready} = '0;
    greq = 1'b1;
    strb = 4'hf;
    {awaddr, wdata, araddr} = '0;
    trip_mode = 2'd0;
    uvlo = 1'b1;
    temp = 8'd140;
    seed = 32'd15;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({shut, gate, scale, 20'(st)}, {1'b1, 1'b0, 10'd1000, 20'(LDP_S_UVLO)});
    rd(32'h0, 32'h0, 2'b00);
    rd(32'h8, 32'd1000, 2'b00);
    v = xs();
    v = {28'h0, 2'(v[3:2] % 3), 2'(v[1:0] % 3)};
    wr(32'h0, v, 2'b00);
    rd(32'h0, v, 2'b00);
    strb <= 4'he;
    wr(32'h0, 32'hf, 2'b00);
    rd(32'h0, v, 2'b00);
    strb <= 4'hf;
    wr(32'h4, 32'h1, 2'b10);
    wr(32'h10, 32'h1, 2'b10);
    rd(32'hc, 32'h0, 2'b10);
    wr(32'h0, 32'h0, 2'b00);
    uvlo <= 1'b0;
    repeat (200) @(posedge aclk);
    chk(shut, 1'b1);
    temp <= 8'd25;
    restart(LDP_S_RUN);
    trip_mode <= 2'd2;
    wt(2, 0, 700);
    wt(2, 1, 700);
    chk(st, LDP_S_RUN);
    greq <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(gate, 1'b0);
    greq <= 1'b1;
    trip_mode <= 2'd0;
    @(posedge aclk);
    trip_mode <= 2'd1;
    wt(0, LDP_S_FAULT, 3000);
    rd(32'h4, 32'h104, 2'b00);
    trip_mode <= 2'd0;
    repeat (50) @(posedge aclk);
    chk(st, LDP_S_FAULT);
    restart(LDP_S_RUN);
    uvlo <= 1'b1;
    repeat (6) @(posedge aclk);
    uvlo <= 1'b0;
    wt(0, LDP_S_SOFT, 100);
    short_g <= 1'b1;
    wt(0, LDP_S_FAULT, 20);
    repeat (3) restart(LDP_S_FAULT);
    short_g <= 1'b0;
    restart(LDP_S_RUN);
    out_short <= 1'b1;
    wt(0, LDP_S_FAULT, 3000);
    rd(32'h4, 32'h304, 2'b00);
    out_short <= 1'b0;
    restart(LDP_S_RUN);
    temp <= 8'd99;
    repeat (100) @(posedge aclk);
    chk(scale, 10'd1000);
    repeat (3) begin
      t = 100 + int'(xs() % 45);
      temp <= 8'(t);
      wt(1, exp_sc(100, t), 600);
      temp <= 8'd25;
      wt(1, 32'd1000, 600);
    end
    temp <= 8'd105;
    wt(1, 32'd930, 600);
    temp <= 8'd91;
    repeat (300) @(posedge aclk);
    chk(scale, 10'd930);
    temp <= 8'd89;
    wt(1, 32'd1000, 600);
    wr(32'h0, 32'h2, 2'b00);
    restart(LDP_S_RUN);
    temp <= 8'd115;
    wt(1, exp_sc(110, 115), 600);
    temp <= 8'd150;
    wt(0, LDP_S_FAULT, 100);
    rd(32'h4, 32'h404, 2'b00);
    end_sim();
  end
endmodule : ldp_fault_derate_bench

// *** tb/ldp_fault_derate_sva.sv ***
`timescale 1ns/1ps
module ldp_fault_derate_sva
  import ldp_pkg::*;
(
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                overcurrent_trip,
  input wire logic                sense_short_guard,
  input wire logic                uvlo_active,
  input wire logic [7:0]          temp_c,
  input wire logic                gate_drive,
  input wire logic                shutdown,
  input wire logic [9:0]          current_scale,
  input wire ldp_pkg::ldp_state_t ctrl_state
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Four samples cover the two-flop sync and the gate_drive output register.
  sequence trip_held;
    overcurrent_trip [*4];
  endsequence
  sequence soft_short;
    (ctrl_state == LDP_S_SOFT && sense_short_guard) [*4];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  shut_state_a: assert property (shutdown == !(ctrl_state inside {LDP_S_SOFT, LDP_S_RUN}))
    else $error("shutdown disagrees with state");
  gate_off_a: assert property (gate_drive |-> !shutdown)
    else $error("gate on while shut down");
  trip_cut_a: assert property (trip_held |-> !gate_drive)
    else $error("gate not cut on trip");
  fault_hold_a: assert property (ctrl_state == LDP_S_FAULT && !uvlo_active && !$past(uvlo_active)
    && !$past(uvlo_active, 2) |=> ctrl_state == LDP_S_FAULT) else $error("fault left without lockout");
  soft_short_a: assert property (soft_short |=> ctrl_state == LDP_S_FAULT)
    else $error("sense short not shut down");
  start_hot_a: assert property (ctrl_state == LDP_S_CHECK && temp_c > 8'd130 && $past(temp_c) > 8'd130
    |=> ctrl_state != LDP_S_SOFT) else $error("hot start allowed");
  hot_shut_a: assert property ((ctrl_state == LDP_S_RUN && temp_c >= 8'd150) [*2]
    |=> ctrl_state != LDP_S_RUN) else $error("no thermal shutdown");
  scale_top_a: assert property (ctrl_state != LDP_S_RUN && $past(ctrl_state) != LDP_S_RUN
    |-> current_scale == 10'd1000) else $error("scale not nominal outside run");
  scale_floor_a: assert property (current_scale >= 10'd720 && current_scale <= 10'd1000)
    else $error("scale out of range");
  scale_slew_a: assert property (ctrl_state == LDP_S_RUN && $past(ctrl_state) == LDP_S_RUN
    |-> current_scale <= $past(current_scale) + 10'd14 && current_scale + 10'd14 >= $past(current_scale))
    else $error("scale step too large");
endmodule : ldp_fault_derate_sva

bind ldp_fault_derate ldp_fault_derate_sva i_ldp_fault_derate_sva (.aclk(aclk), .aresetn(aresetn),
  .overcurrent_trip(overcurrent_trip), .sense_short_guard(sense_short_guard), .uvlo_active(uvlo_active),
  .temp_c(temp_c), .gate_drive(gate_drive), .shutdown(shutdown), .current_scale(current_scale),
  .ctrl_state(ctrl_state));

// *** tb/ldp_plant_model.sv ***
`timescale 1ns/1ps
module ldp_plant_model #(
  parameter int RAMP = 20
) (
  input  wire logic       aclk,
  input  wire logic       gate_drive,
  input  wire logic [1:0] trip_mode,
  output      logic       overcurrent_trip
);
  // Mode 1 trips every pulse, mode 2 trips one pulse only.
  int   on_cnt = 0;
  logic fired  = 1'b0;
  assign overcurrent_trip = (trip_mode == 2'd1 || (trip_mode == 2'd2 && !fired)) && on_cnt >= RAMP;
  // Current keeps ramping while the gate is on and collapses once it is off.
  always @(posedge aclk) begin
    on_cnt <= gate_drive ? on_cnt + 1 : 0;
    if (trip_mode == 2'd0)
      fired <= 1'b0;
    else if (overcurrent_trip && !gate_drive)
      fired <= 1'b1;
  end
endmodule : ldp_plant_model
